//--- sfs_fault_status.sv
// Supply and driver fault status register, read over the serial link.
// Assumes detector inputs are asynchronous levels and that the master waits
// at least three core clocks between csn_n falling and the first sclk edge.
//
// What this block does
// RULE1: A frame addressed to this register returns its 16 bits as the upper then the lower byte.
// RULE2: Bits 15 to 11 latch open-load events of the general output and outputs four to one.
// RULE3: With lockout off, bit 10 shows the live undervoltage condition.
// RULE4: With lockout on, bit 10 latches undervoltage until a read-and-clear.
// RULE5: Bit 9 latches when the second regulator stays low for longer than 2 us.
// RULE6: Bit 8 latches when the second regulator stays low for longer than 4 ms at start-up.
// RULE7: With lockout off, bit 7 shows the live overvoltage condition.
// RULE8: With lockout on, bit 7 latches overvoltage until a read-and-clear.
// RULE9: Bits 6 to 0 latch overcurrent events of the general output, outputs and relays.
// RULE10: Any set bit among bits 10 to 0 raises the global error flag.
// RULE11: A read-and-clear returns the bits, then clears only those returned, new events win.
`timescale 1ns/1ps
`include "sfs_map.svh"
module sfs_fault_status #(
    parameter int SHORT_CYC = `SFS_SHORT_CYC
) (
    // Core clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial link
    input wire logic sclk,
    input wire logic csn_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Detector levels
    input wire logic [4:0] open_load,
    input wire logic [6:0] overcurrent,
    input wire logic uv_cond,
    input wire logic ov_cond,
    input wire logic v2_low,
    input wire logic v2_startup,
    // Setting from the control word four
    input wire logic supply_fault_lockout_enable,
    // Status out
    output logic [15:0] status,
    output logic global_error_flag
);
    localparam int FAIL_CYC = `SFS_FAIL_CYC;

    sfs_pkg::sfs_pin_type pins_raw;
    sfs_pkg::sfs_pin_type pins;
    logic rc_valid_link;
    logic [15:0] status_q;
    logic [15:0] status_d;
    logic [15:0] snap_q;
    logic gef_snap_q;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic sel_prev_q;
    logic rc_fire;
    logic gef_q;
    logic [9:0] fail_cnt_q;
    logic [31:0] short_cnt_q;
    logic reg_fail_evt;
    logic reg_short_evt;

    assign pins_raw = '{
        sel: ~csn_n,
        rc_valid: rc_valid_link,
        lockout_en: supply_fault_lockout_enable,
        v2_startup: v2_startup,
        v2_low: v2_low,
        ov_cond: ov_cond,
        uv_cond: uv_cond,
        open_load: open_load,
        overcurrent: overcurrent
    };

    sfs_sync #(
        .WIDTH($bits(sfs_pkg::sfs_pin_type))
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_lvl(pins_raw),
        .sync_lvl(pins)
    );

    sfs_serial_link u_link (
        .sclk(sclk),
        .csn_n(csn_n),
        .mosi(mosi),
        .miso(miso),
        .miso_oe(miso_oe),
        .rst(rst),
        .snap(snap_q),
        .gef_snap(gef_snap_q),
        .rc_valid(rc_valid_link)
    );

    // End of frame seen in the core domain; rc_valid is stable by then.
    // Select is synced active high so its reset value is the idle level.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= pins.sel;
        end
    end
    assign rc_fire = !pins.sel && sel_prev_q && pins.rc_valid;

    // Snapshot follows status while idle and freezes for the whole frame;
    // the link reads it unsynchronised, safe only because it stands still
    always_ff @(posedge mclk) begin
        if (rst) begin
            snap_q <= `SFS_RESET;
            gef_snap_q <= 1'b0;
        end else if (!pins.sel && !sel_prev_q) begin
            snap_q <= status_q;
            gef_snap_q <= gef_q;
        end
    end

    // Second regulator low time, counted in core cycles
    always_ff @(posedge mclk) begin
        if (rst || !pins.v2_low) begin
            fail_cnt_q <= 10'h000;
        end else if (fail_cnt_q <= 10'(FAIL_CYC)) begin
            fail_cnt_q <= fail_cnt_q + 10'h001;
        end
    end
    assign reg_fail_evt = pins.v2_low && (fail_cnt_q >= 10'(FAIL_CYC)); // RULE5

    // Long count is a parameter so simulation can shorten it
    always_ff @(posedge mclk) begin
        if (rst || !(pins.v2_low && pins.v2_startup)) begin
            short_cnt_q <= 32'h0000_0000;
        end else if (short_cnt_q <= 32'(SHORT_CYC)) begin
            short_cnt_q <= short_cnt_q + 32'h0000_0001;
        end
    end
    assign reg_short_evt = pins.v2_low && pins.v2_startup
        && (short_cnt_q >= 32'(SHORT_CYC)); // RULE6

    always_comb begin
        set_vec = 16'h0000;
        set_vec[`SFS_OL_HI:`SFS_OL_LO] = pins.open_load; // RULE2
        set_vec[`SFS_UV] = pins.uv_cond;
        set_vec[`SFS_REG_FAIL] = reg_fail_evt;
        set_vec[`SFS_REG_SHORT] = reg_short_evt;
        set_vec[`SFS_OV] = pins.ov_cond;
        set_vec[`SFS_OC_HI:0] = pins.overcurrent; // RULE9
    end

    // Only bits that were returned are cleared; set wins over clear
    assign clr_vec = rc_fire ? snap_q : 16'h0000; // RULE11

    always_comb begin
        status_d = (status_q & ~clr_vec) | set_vec;
        if (!pins.lockout_en) begin
            status_d[`SFS_UV] = pins.uv_cond; // RULE3
            status_d[`SFS_OV] = pins.ov_cond; // RULE7
        end
    end

    // With lockout on, bits 10 and 7 take the latched path
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_q <= `SFS_RESET;
        end else begin
            status_q <= status_d; // RULE4 RULE8
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gef_q <= 1'b0;
        end else begin
            gef_q <= |status_d[`SFS_GEF_HI:0]; // RULE10
        end
    end

    assign status = status_q;
    assign global_error_flag = gef_q;

    // Checks
    sequence s_frame_end;
        !pins.sel && sel_prev_q;
    endsequence

    sequence s_rc_fire;
        s_frame_end and pins.rc_valid;
    endsequence

    sequence s_frame_busy;
        pins.sel && sel_prev_q;
    endsequence

    sequence s_frame_idle;
        !pins.sel && !sel_prev_q;
    endsequence

    a_ol_sticky: assert property (@(posedge mclk) disable iff (rst) // RULE2
        status_q[`SFS_OL_HI] && !rc_fire |=> status_q[`SFS_OL_HI])
        else $error("open-load bit dropped without read-and-clear");

    a_oc_capture: assert property (@(posedge mclk) disable iff (rst) // RULE9
        pins.overcurrent[0] |=> status_q[0])
        else $error("overcurrent event not latched");

    a_uv_live: assert property (@(posedge mclk) disable iff (rst) // RULE3
        !pins.lockout_en |=> status_q[`SFS_UV] == $past(pins.uv_cond))
        else $error("undervoltage bit not live with lockout off");

    a_uv_latch: assert property (@(posedge mclk) disable iff (rst) // RULE4
        pins.lockout_en && status_q[`SFS_UV] && !rc_fire |=> status_q[`SFS_UV])
        else $error("undervoltage bit lost with lockout on");

    a_ov_live: assert property (@(posedge mclk) disable iff (rst) // RULE7
        !pins.lockout_en |=> status_q[`SFS_OV] == $past(pins.ov_cond))
        else $error("overvoltage bit not live with lockout off");

    a_ov_latch: assert property (@(posedge mclk) disable iff (rst) // RULE8
        pins.lockout_en && status_q[`SFS_OV] && !rc_fire |=> status_q[`SFS_OV])
        else $error("overvoltage bit lost with lockout on");

    a_reg_fail_time: assert property (@(posedge mclk) disable iff (rst) // RULE5
        $rose(status_q[`SFS_REG_FAIL]) |-> $past(fail_cnt_q) == 10'(FAIL_CYC))
        else $error("regulator fail set at wrong time");

    a_reg_short_time: assert property (@(posedge mclk) disable iff (rst) // RULE6
        $rose(status_q[`SFS_REG_SHORT]) |-> $past(short_cnt_q) == 32'(SHORT_CYC))
        else $error("regulator short set at wrong time");

    a_gef_follow: assert property (@(posedge mclk) disable iff (rst) // RULE10
        |status_q[`SFS_GEF_HI:0] |-> gef_q)
        else $error("global error flag missing");

    a_clear_keeps: assert property (@(posedge mclk) disable iff (rst) // RULE11
        s_rc_fire and pins.overcurrent[0] |=> status_q[0])
        else $error("event lost during read-and-clear");

    a_clear_done: assert property (@(posedge mclk) disable iff (rst) // RULE11
        s_rc_fire and !set_vec[0] and snap_q[0] |=> !status_q[0])
        else $error("returned bit not cleared");

    a_snap_frozen: assert property (@(posedge mclk) disable iff (rst) // RULE1
        s_frame_busy |=> $stable(snap_q))
        else $error("snapshot moved during frame");

    a_gef_snap_frozen: assert property (@(posedge mclk) disable iff (rst) // RULE1
        s_frame_busy |=> $stable(gef_snap_q))
        else $error("global flag snapshot moved during frame");

    a_snap_track: assert property (@(posedge mclk) disable iff (rst) // RULE11
        s_frame_idle |=> snap_q == $past(status_q))
        else $error("snapshot not following status while idle");

    a_ol_capture: assert property (@(posedge mclk) disable iff (rst) // RULE2
        pins.open_load[4] |=> status_q[`SFS_OL_HI])
        else $error("general open-load event not latched");

    a_ol_low_capture: assert property (@(posedge mclk) disable iff (rst) // RULE2
        pins.open_load[0] |=> status_q[`SFS_OL_LO])
        else $error("output one open-load event not latched");

    a_ol_low_sticky: assert property (@(posedge mclk) disable iff (rst) // RULE2
        status_q[`SFS_OL_LO] && !rc_fire |=> status_q[`SFS_OL_LO])
        else $error("output one open-load bit dropped");

    a_oc_capture_hi: assert property (@(posedge mclk) disable iff (rst) // RULE9
        pins.overcurrent[6] |=> status_q[`SFS_OC_HI])
        else $error("general overcurrent event not latched");

    a_oc_sticky: assert property (@(posedge mclk) disable iff (rst) // RULE9
        status_q[`SFS_OC_HI] && !rc_fire |=> status_q[`SFS_OC_HI])
        else $error("general overcurrent bit dropped");

    a_relay_sticky: assert property (@(posedge mclk) disable iff (rst) // RULE9
        status_q[0] && !rc_fire |=> status_q[0])
        else $error("relay one overcurrent bit dropped");

    a_uv_capture: assert property (@(posedge mclk) disable iff (rst) // RULE4
        pins.lockout_en && pins.uv_cond |=> status_q[`SFS_UV])
        else $error("undervoltage event not latched");

    a_ov_capture: assert property (@(posedge mclk) disable iff (rst) // RULE8
        pins.lockout_en && pins.ov_cond |=> status_q[`SFS_OV])
        else $error("overvoltage event not latched");

    a_fail_early: assert property (@(posedge mclk) disable iff (rst) // RULE5
        !status_q[`SFS_REG_FAIL] && (fail_cnt_q < 10'(FAIL_CYC))
        |=> !status_q[`SFS_REG_FAIL])
        else $error("regulator fail set too early");

    a_short_early: assert property (@(posedge mclk) disable iff (rst) // RULE6
        !status_q[`SFS_REG_SHORT] && (short_cnt_q < 32'(SHORT_CYC))
        |=> !status_q[`SFS_REG_SHORT])
        else $error("regulator short set too early");

    a_fail_sticky: assert property (@(posedge mclk) disable iff (rst) // RULE5
        status_q[`SFS_REG_FAIL] && !rc_fire |=> status_q[`SFS_REG_FAIL])
        else $error("regulator fail bit dropped");

    a_short_sticky: assert property (@(posedge mclk) disable iff (rst) // RULE6
        status_q[`SFS_REG_SHORT] && !rc_fire |=> status_q[`SFS_REG_SHORT])
        else $error("regulator short bit dropped");

    a_fail_set: assert property (@(posedge mclk) disable iff (rst) // RULE5
        pins.v2_low && (fail_cnt_q == 10'(FAIL_CYC)) |=> status_q[`SFS_REG_FAIL])
        else $error("regulator fail not latched");

    a_short_set: assert property (@(posedge mclk) disable iff (rst) // RULE6
        pins.v2_low && pins.v2_startup && (short_cnt_q == 32'(SHORT_CYC))
        |=> status_q[`SFS_REG_SHORT])
        else $error("regulator short not latched");

    a_gef_clear: assert property (@(posedge mclk) disable iff (rst) // RULE10
        !(|status_q[`SFS_GEF_HI:0]) |-> !gef_q)
        else $error("global error flag without a set bit");

    a_clear_upper: assert property (@(posedge mclk) disable iff (rst) // RULE11
        s_rc_fire and !set_vec[`SFS_OL_HI] and snap_q[`SFS_OL_HI] |=> !status_q[`SFS_OL_HI])
        else $error("returned open-load bit not cleared");
endmodule

//--- sfs_map.svh
// Constants for the supply and driver fault status block.
// Assumes a 4 ns core clock; included by every design file that needs a figure.
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH
`define SFS_ADDR 6'h11
`define SFS_OP_RC 2'h3
`define SFS_RESET 16'h0000
`define SFS_OL_HI 15
`define SFS_OL_LO 11
`define SFS_UV 10
`define SFS_REG_FAIL 9
`define SFS_REG_SHORT 8
`define SFS_OV 7
`define SFS_OC_HI 6
`define SFS_GEF_HI 10
`define SFS_CLK_NS 4
`define SFS_FAIL_NS 2000
`define SFS_FAIL_CYC ((`SFS_FAIL_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS)
`define SFS_SHORT_MS 4
`define SFS_SHORT_CYC ((`SFS_SHORT_MS * 1000000) / `SFS_CLK_NS)
`define SFS_CMD_BITS 8
`define SFS_FRAME_BITS 24
`endif

//--- sfs_master_model.sv
// Serial master model: runs 24-edge frames and collects the reply bits.
// Assumes the block answers on miso while csn_n is low.
`timescale 1ns/1ps
module sfs_master_model (
    // Link
    output logic sclk,
    output logic csn_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        csn_n = 1'b1;
        mosi = 1'b1;
    end

    // Clock stands still between frames, so mosi toggles to avoid stale data
    task automatic frame(input logic [1:0] op, input logic [5:0] addr, output logic [23:0] rx);
        logic [7:0] cmd;
        cmd = {op, addr};
        rx = 24'h000000;
        csn_n = 1'b0;
        #40;
        for (int i = 0; i < 24; i++) begin
            mosi = (i < 8) ? cmd[7 - i] : ~mosi;
            #31.25;
            rx = {rx[22:0], miso};
            sclk = 1'b1;
            #62.5;
            sclk = 1'b0;
            #31.25;
        end
        csn_n = 1'b1;
        mosi = ~mosi;
        #100;
    endtask
endmodule

//--- sfs_pkg.sv
// Types for the supply and driver fault status block.
// Assumes nothing beyond the map header.
package sfs_pkg;
    typedef struct packed {
        logic sel;
        logic rc_valid;
        logic lockout_en;
        logic v2_startup;
        logic v2_low;
        logic ov_cond;
        logic uv_cond;
        logic [4:0] open_load;
        logic [6:0] overcurrent;
    } sfs_pin_type;

    typedef struct packed {
        logic [1:0] op;
        logic [5:0] addr;
    } sfs_cmd_type;
endpackage

//--- sfs_serial_link.sv
// Serial slave front end on the link clock: command byte in, global byte
// and 16 status bits out, MSB first. Assumes sclk idles low and the master
// samples on the rising edge; the snapshot is frozen while csn_n is low.
`timescale 1ns/1ps
`include "sfs_map.svh"
module sfs_serial_link (
    // Link
    input wire logic sclk,
    input wire logic csn_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Core side, quasi-static during a frame
    input wire logic rst,
    input wire logic [15:0] snap,
    input wire logic gef_snap,
    output logic rc_valid
);
    logic [4:0] cnt_q;
    logic [7:0] cmd_q;
    logic rc_q;
    sfs_pkg::sfs_cmd_type cmd;
    logic [23:0] frame;

    assign cmd = sfs_pkg::sfs_cmd_type'(cmd_q);
    // Frame reset by csn_n itself, since sclk stops between frames
    always_ff @(posedge sclk or posedge csn_n) begin
        if (csn_n) begin
            cnt_q <= 5'h00;
            cmd_q <= 8'h00;
        end else begin
            if (cnt_q < 5'(`SFS_CMD_BITS)) begin
                cmd_q <= {cmd_q[6:0], mosi};
            end
            if (cnt_q <= 5'(`SFS_FRAME_BITS)) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // Held past csn_n rising so the core can sample it; overlong frames drop it
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            rc_q <= 1'b0;
        end else if (cnt_q == 5'(`SFS_FRAME_BITS - 1)) begin
            rc_q <= (cmd.op == `SFS_OP_RC) && (cmd.addr == `SFS_ADDR);
        end else begin
            rc_q <= 1'b0;
        end
    end
    assign rc_valid = rc_q;

    // RULE1
    assign frame = {gef_snap, 7'h00,
        (cmd.addr == `SFS_ADDR) ? snap : 16'h0000};
    // Low while deselected so the line never shows a stale bit
    assign miso = (!csn_n && (cnt_q < 5'(`SFS_FRAME_BITS))) ?
        frame[5'(`SFS_FRAME_BITS - 1) - cnt_q] : 1'b0;
    assign miso_oe = ~csn_n;
endmodule

//--- sfs_sync.sv
// Two-flop level synchroniser, one chain per bit.
// Assumes the inputs are levels that stay put for several clock periods.
`timescale 1ns/1ps
module sfs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] async_lvl,
    output logic [WIDTH-1:0] sync_lvl
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_q;
            logic stab_q;
            always_ff @(posedge mclk) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    stab_q <= 1'b0;
                end else begin
                    meta_q <= async_lvl[i];
                    stab_q <= meta_q;
                end
            end
            assign sync_lvl[i] = stab_q;
        end
    endgenerate
endmodule

//--- test_sfs_fault_status.sv
// Self-checking bench for the fault status register.
// Assumes the master model drives the link; detector levels come from here.
`timescale 1ns/1ps
module test_sfs_fault_status;
    // Core side
    logic mclk;
    logic rst;
    sfs_pkg::sfs_pin_type pin;
    logic [15:0] status;
    logic gef;
    // Link
    logic sclk;
    logic csn_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [23:0] rx;
    int compares = 0;
    int bad_count = 0;

    // Short start-up count keeps the run brief
    sfs_fault_status #(.SHORT_CYC(50)) DUT (
        .mclk(mclk), .rst(rst), .sclk(sclk), .csn_n(csn_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .open_load(pin.open_load),
        .overcurrent(pin.overcurrent), .uv_cond(pin.uv_cond), .ov_cond(pin.ov_cond),
        .v2_low(pin.v2_low), .v2_startup(pin.v2_startup),
        .supply_fault_lockout_enable(pin.lockout_en), .status(status),
        .global_error_flag(gef)
    );

    sfs_master_model master (.sclk(sclk), .csn_n(csn_n), .mosi(mosi), .miso(miso));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Clear takes effect a few core clocks after the frame ends
    task automatic rd(input logic [1:0] op, input logic [5:0] a);
        master.frame(op, a, rx);
        cyc(8);
    endtask

    task automatic wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        pin = '0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        cyc(4);
        chk(status, 16'h0000);
        chk({15'h0000, gef}, 16'h0000);
        chk({15'h0000, miso_oe}, 16'h0000);
        @(posedge mclk) begin pin.open_load <= 5'h1F; pin.overcurrent <= 7'h7F; end
        cyc(4);
        @(posedge mclk) begin pin.open_load <= 5'h00; pin.overcurrent <= 7'h00; end
        cyc(6);
        chk(status, 16'hF87F);
        chk({15'h0000, gef}, 16'h0001);
        rd(2'h0, 6'h11);
        chk(rx[15:0], 16'hF87F);
        chk({8'h00, rx[23:16]}, 16'h0080);
        chk(status, 16'hF87F);
        rd(2'h3, 6'h12);
        chk(rx[15:0], 16'h0000);
        chk(status, 16'hF87F);
        @(posedge mclk) pin.overcurrent <= 7'h01;
        rd(2'h3, 6'h11);
        chk(rx[15:0], 16'hF87F);
        chk(status, 16'h0001);
        @(posedge mclk) pin.overcurrent <= 7'h00;
        rd(2'h3, 6'h11);
        chk(status, 16'h0000);
        chk(rx[15:0], 16'h0001);
        chk({15'h0000, gef}, 16'h0000);
        $display("driver event test done");
        for (int lk = 0; lk < 2; lk++) begin
            @(posedge mclk) begin pin.lockout_en <= lk[0]; pin.uv_cond <= 1'b1; end
            @(posedge mclk) pin.ov_cond <= 1'b1;
            cyc(6);
            chk(status, 16'h0480);
            @(posedge mclk) begin pin.uv_cond <= 1'b0; pin.ov_cond <= 1'b0; end
            cyc(6);
            chk(status, lk ? 16'h0480 : 16'h0000);
        end
        chk({15'h0000, gef}, 16'h0001);
        rd(2'h3, 6'h11);
        chk(status, 16'h0000);
        $display("supply voltage test done");
        @(posedge mclk) pin.v2_low <= 1'b1;
        cyc(500);
        chk(status, 16'h0000);
        cyc(10);
        chk(status, 16'h0200);
        @(posedge mclk) pin.v2_low <= 1'b0;
        cyc(6);
        chk(status, 16'h0200);
        @(posedge mclk) begin pin.v2_low <= 1'b1; pin.v2_startup <= 1'b1; end
        cyc(50);
        chk(status, 16'h0200);
        cyc(10);
        chk(status, 16'h0300);
        @(posedge mclk) begin pin.v2_low <= 1'b0; pin.v2_startup <= 1'b0; end
        rd(2'h3, 6'h11);
        chk(rx[15:0], 16'h0300);
        chk(status, 16'h0000);
        $display("regulator test done");
        @(posedge mclk) pin.overcurrent <= 7'h40;
        cyc(6);
        chk(status, 16'h0040);
        @(posedge mclk) begin pin.overcurrent <= 7'h00; rst <= 1'b1; end
        cyc(4);
        @(posedge mclk) rst <= 1'b0;
        cyc(4);
        chk(status, 16'h0000);
        chk({15'h0000, gef}, 16'h0000);
        rd(2'h0, 6'h11);
        chk(rx[15:0], 16'h0000);
        chk({8'h00, rx[23:16]}, 16'h0000);
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule
